// ==== common/swt_pkg.sv ====
/*
  Package of the system options and wakeup timer group: register
  offsets, field positions, reset values and timing counts.
  Assumes a 25 MHz system clock and a 32-bit classic Wishbone bus.
*/
package swt_pkg;
  localparam logic [7:0] SWT_ADR_OPTIONS_TWO = 8'h00;
  localparam logic [7:0] SWT_ADR_PART_ID_HIGH = 8'h04;
  localparam logic [7:0] SWT_ADR_PART_ID_LOW = 8'h08;
  localparam logic [7:0] SWT_ADR_WAKEUP_SC = 8'h0C;

  localparam int SWT_BIT_WDOG_CLKSEL = 7;
  localparam int SWT_BIT_I2C_PINSEL = 1;
  localparam int SWT_BIT_CMP_CAPTURE = 0;
  localparam int SWT_BIT_WAKE_FLAG = 7;
  localparam int SWT_BIT_WAKE_ACK = 6;
  localparam int SWT_BIT_WAKE_CLKSEL = 5;
  localparam int SWT_BIT_WAKE_IRQEN = 4;
  localparam int SWT_PERIOD_MSB = 2;

  localparam logic [7:0] SWT_OPTIONS_TWO_RESET = 8'h00;
  localparam logic [7:0] SWT_WAKEUP_SC_RESET = 8'h00;
  localparam logic [3:0] SWT_ID_HIGH_RESERVED = 4'h0;

  localparam int SWT_CLK_HZ = 25000000;
  localparam int SWT_TICK_HZ = 1000;
  localparam int SWT_TICK_CYCLES = SWT_CLK_HZ / SWT_TICK_HZ;
  localparam int SWT_PIN_SYNC_STAGES = 3;
endpackage

// ==== common/swt_tick_if.sv ====
/*
  Interface carrying the 1 kHz tick and external clock event from the
  tick generator to the register group. One clock domain assumed.
*/
`timescale 1ns/1ps
`default_nettype none
interface swt_tick_if;
  logic tick_1khz;
  logic ext_edge;
  modport gen (output tick_1khz, output ext_edge);
  modport use_side (input tick_1khz, input ext_edge);
endinterface
`default_nettype wire

// ==== src/swt_tick_gen.sv ====
/*
  Tick generator: divides the system clock to a 1 kHz enable pulse and
  turns the external crystal pin into a one-cycle rising edge event.
  Assumes the crystal is far slower than the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module swt_tick_gen #(
  parameter int TICK_CYCLES = swt_pkg::SWT_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_clk_pin,
  swt_tick_if.gen tick
);
  localparam int CW = $clog2(TICK_CYCLES);
  logic [CW-1:0] div_q;
  logic [2:0] sync_q;
  logic ext_level_q;
  wire div_wrap = (div_q == CW'(TICK_CYCLES - 1));
  // Change counts once stages two and three agree
  wire ext_stable = (sync_q[1] == sync_q[2]);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_wrap ? '0 : div_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_q <= 3'h0;
      ext_level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], ext_clk_pin};
      if (ext_stable) begin
        ext_level_q <= sync_q[2];
      end
    end
  end

  assign tick.tick_1khz = div_wrap;
  assign tick.ext_edge = ext_stable && sync_q[2] && !ext_level_q;
endmodule
`default_nettype wire

// ==== src/swt_sys_regs.sv ====
/*
  System options two, part identification pair and periodic wakeup
  timer, as a classic Wishbone slave with 32-bit data.
  Assumes single-cycle classic masters and one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module swt_sys_regs #(
  parameter logic [11:0] PART_NUMBER = 12'h5A3, // Arbitrary value
  parameter int TICK_CYCLES = swt_pkg::SWT_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic ext_clk_pin,
  output logic watchdog_clock_select,
  output logic i2c_pin_select,
  output logic comparator_to_capture_enable,
  output logic wakeup_irq,
  output logic wakeup_timeout_pulse
);
  swt_tick_if tick_bus ();

  swt_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .ext_clk_pin(ext_clk_pin),
    .tick(tick_bus)
  );

  function automatic logic [15:0] period_count(input logic ext_sel, input logic [2:0] code);
    logic [15:0] n;
    n = 16'h0000;
    if (ext_sel) begin
      unique case (code)
        3'h1: n = 16'h00FF;
        3'h2: n = 16'h03FF;
        3'h3: n = 16'h07FF;
        3'h4: n = 16'h0FFF;
        3'h5: n = 16'h1FFF;
        3'h6: n = 16'h3FFF;
        3'h7: n = 16'h7FFF;
        default: n = 16'h0000;
      endcase
    end else begin
      unique case (code)
        3'h1: n = 16'h0007;
        3'h2: n = 16'h001F;
        3'h3: n = 16'h003F;
        3'h4: n = 16'h007F;
        3'h5: n = 16'h00FF;
        3'h6: n = 16'h01FF;
        3'h7: n = 16'h03FF;
        default: n = 16'h0000;
      endcase
    end
    return n;
  endfunction

  // Register state
  logic wdog_sel_q;
  logic wdog_locked_q;
  logic i2c_sel_q;
  logic cmp_cap_q;
  logic wake_flag_q;
  logic wake_clksel_q;
  logic wake_irqen_q;
  logic [2:0] wake_period_q;
  logic [15:0] wake_cnt_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // Bus decode; answer one cycle after the request, ack dropped after
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire lane0 = wb_sel_i[0];
  wire hit_opt = (wb_adr_i == swt_pkg::SWT_ADR_OPTIONS_TWO);
  wire hit_idh = (wb_adr_i == swt_pkg::SWT_ADR_PART_ID_HIGH);
  wire hit_idl = (wb_adr_i == swt_pkg::SWT_ADR_PART_ID_LOW);
  wire hit_wsc = (wb_adr_i == swt_pkg::SWT_ADR_WAKEUP_SC);
  wire mapped = hit_opt || hit_idh || hit_idl || hit_wsc;
  wire wr_opt = req && wb_we_i && lane0 && hit_opt;
  wire wr_wsc = req && wb_we_i && lane0 && hit_wsc;

  wire [7:0] opt_rd = {wdog_sel_q, 5'h00, i2c_sel_q, cmp_cap_q};
  // Reserved nibble reads a fixed zero; ID writes fall through unused
  wire [7:0] idh_rd = {swt_pkg::SWT_ID_HIGH_RESERVED, PART_NUMBER[11:8]};
  wire [7:0] idl_rd = PART_NUMBER[7:0];
  // Acknowledge and bit 3 always read zero
  wire [7:0] wsc_rd = {wake_flag_q, 1'b0, wake_clksel_q, wake_irqen_q, 1'b0, wake_period_q};
  wire [7:0] rd_mux = hit_opt ? opt_rd :
                      hit_idh ? idh_rd :
                      hit_idl ? idl_rd :
                      hit_wsc ? wsc_rd : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) begin
        rdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  assign wb_ack_o = ack_q && mapped;
  assign wb_err_o = ack_q && !mapped;
  assign wb_dat_o = rdata_q;

  // Options register two
  wire wdog_wr = wr_opt && !wdog_locked_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      wdog_sel_q <= swt_pkg::SWT_OPTIONS_TWO_RESET[swt_pkg::SWT_BIT_WDOG_CLKSEL];
      wdog_locked_q <= 1'b0;
      i2c_sel_q <= swt_pkg::SWT_OPTIONS_TWO_RESET[swt_pkg::SWT_BIT_I2C_PINSEL];
      cmp_cap_q <= swt_pkg::SWT_OPTIONS_TWO_RESET[swt_pkg::SWT_BIT_CMP_CAPTURE];
    end else begin
      if (wdog_wr) begin
        wdog_sel_q <= wb_dat_i[swt_pkg::SWT_BIT_WDOG_CLKSEL];
        wdog_locked_q <= 1'b1;
      end
      if (wr_opt) begin
        i2c_sel_q <= wb_dat_i[swt_pkg::SWT_BIT_I2C_PINSEL];
        cmp_cap_q <= wb_dat_i[swt_pkg::SWT_BIT_CMP_CAPTURE];
      end
    end
  end

  assign watchdog_clock_select = wdog_sel_q;
  assign i2c_pin_select = i2c_sel_q;
  assign comparator_to_capture_enable = cmp_cap_q;

  // Wakeup control fields
  wire [2:0] new_period = wb_dat_i[swt_pkg::SWT_PERIOD_MSB:0];
  wire new_clksel = wb_dat_i[swt_pkg::SWT_BIT_WAKE_CLKSEL];
  wire cfg_change = wr_wsc && ((new_period != wake_period_q) || (new_clksel != wake_clksel_q));
  wire ack_write = wr_wsc && wb_dat_i[swt_pkg::SWT_BIT_WAKE_ACK];

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_clksel_q <= swt_pkg::SWT_WAKEUP_SC_RESET[swt_pkg::SWT_BIT_WAKE_CLKSEL];
      wake_irqen_q <= swt_pkg::SWT_WAKEUP_SC_RESET[swt_pkg::SWT_BIT_WAKE_IRQEN];
      wake_period_q <= swt_pkg::SWT_WAKEUP_SC_RESET[swt_pkg::SWT_PERIOD_MSB:0];
    end else if (wr_wsc) begin
      wake_clksel_q <= new_clksel;
      wake_irqen_q <= wb_dat_i[swt_pkg::SWT_BIT_WAKE_IRQEN];
      wake_period_q <= new_period;
    end
  end

  // Timer count; the 1 kHz divider free-runs, so the first tick
  // after a restart can come early by up to one tick period.
  wire src_tick = wake_clksel_q ? tick_bus.ext_edge : tick_bus.tick_1khz;
  wire timer_on = (wake_period_q != 3'h0);
  wire [15:0] last_count = period_count(wake_clksel_q, wake_period_q);
  wire timeout = timer_on && src_tick && (wake_cnt_q == last_count);

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_cnt_q <= 16'h0000;
    end else if (cfg_change || !timer_on || timeout) begin
      wake_cnt_q <= 16'h0000;
    end else if (src_tick) begin
      wake_cnt_q <= wake_cnt_q + 16'h0001;
    end
  end

  // Flag: a timeout in the acknowledge cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_flag_q <= 1'b0;
    end else if (timeout) begin
      wake_flag_q <= 1'b1;
    end else if (ack_write) begin
      wake_flag_q <= 1'b0;
    end
  end

  assign wakeup_irq = wake_flag_q && wake_irqen_q;
  assign wakeup_timeout_pulse = timeout;

  // Checks
  lock_hold_a: assert property (@(posedge clk) disable iff (rst)
    wdog_locked_q && wr_opt |=> $stable(wdog_sel_q))
    else $error("watchdog select changed after lock");
  first_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_opt && !wdog_locked_q |=> wdog_sel_q == $past(wb_dat_i[7]) && wdog_locked_q)
    else $error("first watchdog select write lost");
  pin_select_a: assert property (@(posedge clk) disable iff (rst)
    wr_opt |=> i2c_sel_q == $past(wb_dat_i[1]) && cmp_cap_q == $past(wb_dat_i[0]))
    else $error("options write not stored");
  id_const_a: assert property (@(posedge clk) disable iff (rst)
    ack_q && $past(hit_idl) |-> wb_dat_o == {24'h000000, PART_NUMBER[7:0]})
    else $error("part id low wrong");
  id_reserved_a: assert property (@(posedge clk) disable iff (rst)
    ack_q && $past(hit_idh) |-> wb_dat_o[31:4] == 28'h0000000)
    else $error("part id high upper bits wrong");
  flag_set_a: assert property (@(posedge clk) disable iff (rst)
    timeout |=> wake_flag_q)
    else $error("timeout did not set flag");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    ack_write && !timeout |=> !wake_flag_q)
    else $error("acknowledge did not clear flag");
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    wake_flag_q && !ack_write |=> wake_flag_q)
    else $error("flag dropped without acknowledge");
  irq_gate_a: assert property (@(posedge clk) disable iff (rst)
    wakeup_irq == (wake_flag_q && wake_irqen_q))
    else $error("interrupt gating wrong");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
    wake_period_q == 3'h0 |-> !timeout)
    else $error("timeout while disabled");
  restart_cnt_a: assert property (@(posedge clk) disable iff (rst)
    cfg_change || timeout |=> wake_cnt_q == 16'h0000)
    else $error("counter not restarted");
  ack_once_a: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ext_period_a: assert property (@(posedge clk) disable iff (rst)
    timeout && wake_clksel_q && wake_period_q == 3'h1 |-> wake_cnt_q == 16'h00FF)
    else $error("external period wrong");
  int_period_a: assert property (@(posedge clk) disable iff (rst)
    timeout && !wake_clksel_q && wake_period_q == 3'h1 |-> wake_cnt_q == 16'h0007)
    else $error("internal period wrong");

  // Bus answer: exactly one of ack or err, one cycle after the take
  answer_excl_a: assert property (@(posedge clk) disable iff (rst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");

  answer_follows_a: assert property (@(posedge clk) disable iff (rst)
    req |=> (wb_ack_o || wb_err_o))
    else $error("request not answered");

  no_spurious_ack_a: assert property (@(posedge clk) disable iff (rst)
    !req |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");

  dat_upper_a: assert property (@(posedge clk) disable iff (rst)
    wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");

  idh_number_a: assert property (@(posedge clk) disable iff (rst)
    ack_q && $past(hit_idh) |-> wb_dat_o[3:0] == PART_NUMBER[11:8])
    else $error("part id high number wrong");

  // Options two outputs and the write-once lock
  wdog_out_a: assert property (@(posedge clk) disable iff (rst)
    watchdog_clock_select == wdog_sel_q)
    else $error("watchdog select output wrong");

  lock_set_a: assert property (@(posedge clk) disable iff (rst)
    wr_opt |=> wdog_locked_q)
    else $error("lock not taken");

  lock_stays_a: assert property (@(posedge clk) disable iff (rst)
    wdog_locked_q |=> wdog_locked_q)
    else $error("lock dropped before reset");

  opt_keep_a: assert property (@(posedge clk) disable iff (rst)
    !wr_opt |=> $stable(i2c_sel_q) && $stable(cmp_cap_q))
    else $error("options changed without write");

  route_out_a: assert property (@(posedge clk) disable iff (rst)
    comparator_to_capture_enable == cmp_cap_q)
    else $error("capture route output wrong");

  // Wakeup register reads and stores
  wsc_flag_rd_a: assert property (@(posedge clk) disable iff (rst)
    ack_q && $past(hit_wsc) |-> wb_dat_o[7] == $past(wake_flag_q))
    else $error("flag read wrong");

  wsc_ack_rd_a: assert property (@(posedge clk) disable iff (rst)
    ack_q && $past(hit_wsc) |-> wb_dat_o[6] == 1'b0)
    else $error("acknowledge bit read nonzero");

  clksel_store_a: assert property (@(posedge clk) disable iff (rst)
    wr_wsc |=> wake_clksel_q == $past(wb_dat_i[5]))
    else $error("clock select not stored");

  irqen_store_a: assert property (@(posedge clk) disable iff (rst)
    wr_wsc |=> wake_irqen_q == $past(wb_dat_i[4]))
    else $error("interrupt enable not stored");

  period_store_a: assert property (@(posedge clk) disable iff (rst)
    wr_wsc |=> wake_period_q == $past(wb_dat_i[2:0]))
    else $error("period not stored");

  // Counter behaviour between timeouts
  cnt_idle_a: assert property (@(posedge clk) disable iff (rst)
    !timer_on |=> wake_cnt_q == 16'h0000)
    else $error("counter runs while disabled");

  cnt_step_a: assert property (@(posedge clk) disable iff (rst)
    timer_on && src_tick && !timeout && !cfg_change |=>
      wake_cnt_q == $past(wake_cnt_q) + 16'h0001)
    else $error("counter missed a tick");

  cnt_hold_a: assert property (@(posedge clk) disable iff (rst)
    timer_on && !src_tick && !cfg_change |=> $stable(wake_cnt_q))
    else $error("counter moved without tick");

  cnt_bound_a: assert property (@(posedge clk) disable iff (rst)
    timer_on |-> wake_cnt_q <= last_count)
    else $error("counter beyond period");

  ext_top_a: assert property (@(posedge clk) disable iff (rst)
    timeout && wake_clksel_q && wake_period_q == 3'h7 |-> wake_cnt_q == 16'h7FFF)
    else $error("longest external period wrong");

  int_top_a: assert property (@(posedge clk) disable iff (rst)
    timeout && !wake_clksel_q && wake_period_q == 3'h7 |-> wake_cnt_q == 16'h03FF)
    else $error("longest internal period wrong");

  irq_needs_flag_a: assert property (@(posedge clk) disable iff (rst)
    wakeup_irq |-> wake_flag_q)
    else $error("interrupt without flag");

  // Tick sources are single-cycle events
  tick_single_a: assert property (@(posedge clk) disable iff (rst)
    tick_bus.tick_1khz |=> !tick_bus.tick_1khz)
    else $error("tick longer than one cycle");

  ext_single_a: assert property (@(posedge clk) disable iff (rst)
    tick_bus.ext_edge |=> !tick_bus.ext_edge)
    else $error("external edge longer than one cycle");
endmodule
`default_nettype wire

// ==== testbench/swt_sys_regs_bench.sv ====
/*
  Self-checking bench of the options, identification and wakeup timer
  registers, with a small reference model of the register contents.
  Assumes the register group answers on classic Wishbone, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module swt_sys_regs_bench;
  localparam int TK = 10;
  localparam logic [11:0] PART = 12'h3C6; // Arbitrary value
  localparam logic [7:0] A_OPT = swt_pkg::SWT_ADR_OPTIONS_TWO;
  localparam logic [7:0] A_IDH = swt_pkg::SWT_ADR_PART_ID_HIGH;
  localparam logic [7:0] A_IDL = swt_pkg::SWT_ADR_PART_ID_LOW;
  localparam logic [7:0] A_WK = swt_pkg::SWT_ADR_WAKEUP_SC;
  int tab_i[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
  int tab_e[8] = '{0, 256, 1024, 2048, 4096, 8192, 16384, 32768};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic ext_pin = 1'b0;
  logic [31:0] dat_o;
  logic ack, err, wd_sel, i2c_sel, cmp_en, irq, pulse;
  logic [31:0] rd;
  logic er;
  logic [7:0] opt_m = 8'h00;
  logic [7:0] wk_m = 8'h00;
  logic lock_m = 1'b0;
  logic ext_run = 1'b0;
  int n_fail = 0;
  int compares = 0;
  int cyc_cnt = 0;
  int since = 0;
  int gap = 0;
  int npulse = 0;
  int ext_div = 0;
  int t0;
  logic [7:0] v;

  swt_sys_regs #(.PART_NUMBER(PART), .TICK_CYCLES(TK)) u_swt_sys_regs (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .ext_clk_pin(ext_pin),
    .watchdog_clock_select(wd_sel), .i2c_pin_select(i2c_sel),
    .comparator_to_capture_enable(cmp_en), .wakeup_irq(irq),
    .wakeup_timeout_pulse(pulse));

  always #20 clk = ~clk;

  // Pulse spacing monitor, slow crystal stand-in and hang guard
  always @(posedge clk) begin
    cyc_cnt++;
    if (pulse === 1'b1) begin
      gap = since;
      since = 1;
      npulse++;
    end else begin
      since++;
    end
    if (ext_run) begin
      ext_div = (ext_div + 1) % 4;
      if (ext_div == 0) ext_pin <= ~ext_pin;
    end
    if (cyc_cnt == 95000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    opt_m = 8'h00;
    wk_m = 8'h00;
    lock_m = 1'b0;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [7:0] d);
    int n;
    logic [31:0] junk;
    n = 0;
    junk = $urandom();
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {junk[31:8], d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    rd = dat_o;
    er = err;
    if (n >= 20) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, 4'hF, d);
    if (a == A_OPT) begin
      opt_m = {lock_m ? opt_m[7] : d[7], 5'h00, d[1:0]};
      lock_m = 1'b1;
    end
    if (a == A_WK) wk_m = {2'b00, d[5:4], 1'b0, d[2:0]};
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    bus(1'b0, a, 4'hF, 8'h00);
    `CHK("read data", ex, rd)
  endtask

  task automatic wait_pulses(input int k);
    int t;
    t = npulse + k;
    while (npulse < t) @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h7f2e51a4));
    do_reset();
    rd_chk(A_OPT, 32'h0);
    rd_chk(A_IDH, {28'h0, PART[11:8]});
    rd_chk(A_IDL, {24'h0, PART[7:0]});
    rd_chk(A_WK, 32'h0);
    bus(1'b1, A_OPT, 4'hE, 8'hFF);
    rd_chk(A_OPT, 32'h0);
    bus(1'b0, 8'h10, 4'hF, 8'h00);
    `CHK("unmapped err", 1'b1, er)
    wr(A_IDH, 8'hFF);
    wr(A_IDL, ~PART[7:0]);
    rd_chk(A_IDH, {28'h0, PART[11:8]});
    rd_chk(A_IDL, {24'h0, PART[7:0]});
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      wr(A_OPT, v);
      rd_chk(A_OPT, {24'h0, opt_m});
      `CHK("watchdog sel", opt_m[7], wd_sel)
      `CHK("i2c sel", opt_m[1], i2c_sel)
      `CHK("capture route", opt_m[0], cmp_en)
    end
    // Lock must fall away with a second reset
    do_reset();
    wr(A_OPT, 8'h80);
    `CHK("watchdog sel", 1'b1, wd_sel)
    for (int c = 1; c < 8; c++) begin
      wr(A_WK, 8'h10 | 8'(c));
      t0 = cyc_cnt;
      wait_pulses(1);
      `CHK("first timeout", 1'b1, cyc_cnt - t0 <= tab_i[c] * TK + 3)
      `CHK("first not early", 1'b1, cyc_cnt - t0 >= (tab_i[c] - 1) * TK - 2)
      wait_pulses(1);
      `CHK("internal gap", tab_i[c] * TK, gap)
      rd_chk(A_WK, {24'h0, 8'h80 | wk_m});
      `CHK("irq set", 1'b1, irq)
      wr(A_WK, 8'h50 | 8'(c));
      rd_chk(A_WK, {24'h0, wk_m});
      `CHK("irq clear", 1'b0, irq)
    end
    ext_run = 1'b1;
    for (int c = 1; c < 3; c++) begin
      wr(A_WK, 8'h30 | 8'(c));
      wait_pulses(2);
      `CHK("external gap", tab_e[c] * 8, gap)
      wr(A_WK, 8'h70 | 8'(c));
    end
    wr(A_WK, 8'h41);
    t0 = cyc_cnt;
    wait_pulses(1);
    `CHK("restart on select", 1'b1, cyc_cnt - t0 <= tab_i[1] * TK + 3)
    rd_chk(A_WK, {24'h0, 8'h80 | wk_m});
    `CHK("irq masked", 1'b0, irq)
    wr(A_WK, 8'h50);
    t0 = npulse;
    repeat (3000) @(posedge clk);
    `CHK("disabled pulses", t0, npulse)
    rd_chk(A_WK, {24'h0, wk_m});
    finish_test();
  end
endmodule
`default_nettype wire
